// file: ddsl_load.sv
// Serial input, input registers and converter registers of a dual converter.
// Assumes serial pins and strobes come from outside the clk domain.
//
// Behaviour
// - 16-bit words, most significant bit first
// - Shift one bit per serial clock rise
// - Ignore serial clock while select high
// - Bits 15,14 address; 13..0 code
// - Only the last 16 bits used
// - Select rise loads addressed input registers
// - Strobe low makes converter registers transparent
// - Preset low forces zero or half scale
// - Address 00 none, 01 A, 10 B, 11 both
// - Reset sets input and converter registers by level select; shift register clears to zero
// - Chip select never affects strobe path
`timescale 1ns/1ps
module ddsl_load
  import ddsl_pkg::*;
(
  input  wire logic                   clk,                 // System clock 100 MHz
  input  wire logic                   srst,                // Sync reset, active high
  input  wire logic                   chip_select_n,       // Serial frame select pin
  input  wire logic                   serial_clk,          // Serial clock pin
  input  wire logic                   serial_data,         // Serial data pin
  input  wire logic                   converter_load_strobe_n, // Level load strobe
  input  wire logic                   preset_n,            // Preset pin, active low
  input  wire logic                   half_scale_sel,      // Preset level select
  output logic [ddsl_pkg::DDSL_CODE_W-1:0] input_reg_a,      // Input register A
  output logic [ddsl_pkg::DDSL_CODE_W-1:0] input_reg_b,      // Input register B
  output logic [ddsl_pkg::DDSL_CODE_W-1:0] converter_code_a, // Converter register A
  output logic [ddsl_pkg::DDSL_CODE_W-1:0] converter_code_b  // Converter register B
);
  import ddsl_pkg::*;

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  ddsl_pins_t meta_r;                                     // First stage only
  ddsl_pins_t sync_r;                                     // Second stage
  ddsl_pins_t pins_raw;                                   // Pins gathered as one word
  logic       sclk_d_r;                                   // Delayed serial clock
  logic       cs_d_r;                                     // Delayed select

  // Gather the pins so both stages move them together
  assign pins_raw.cs_n     = chip_select_n;
  assign pins_raw.sclk     = serial_clk;
  assign pins_raw.sdata    = serial_data;
  assign pins_raw.strobe_n = converter_load_strobe_n;
  assign pins_raw.preset_n = preset_n;

  // Two flops per pin; preset is synchronised too, so it acts a few cycles late
  // Reset loads each pin's idle level: a reset value of the other polarity
  // would show a false serial clock or select edge right after release
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r   <= DDSL_PIN_IDLE;
      sync_r   <= DDSL_PIN_IDLE;
      sclk_d_r <= DDSL_PIN_IDLE.sclk;
      cs_d_r   <= DDSL_PIN_IDLE.cs_n;
    end else begin
      meta_r   <= pins_raw;
      sync_r   <= meta_r;
      sclk_d_r <= sync_r.sclk;
      cs_d_r   <= sync_r.cs_n;
    end
  end

  wire cs_n_s     = sync_r.cs_n;                          // Select, synchronised
  wire sclk_s     = sync_r.sclk;                          // Serial clock, synced
  wire sdi_s      = sync_r.sdata;                         // Data, synced
  wire strobe_n_s = sync_r.strobe_n;                      // Strobe, synced
  wire pre_n_s    = sync_r.preset_n;                      // Preset, synced
  logic lvl_r;                                            // Level select, 2 flops
  logic lvl_m_r;                                          // Level select stage 1

  always_ff @(posedge clk) begin
    lvl_m_r <= half_scale_sel;
    lvl_r   <= lvl_m_r;
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire shift_en = ~cs_n_s & sclk_s & ~sclk_d_r;
  wire load_en  = cs_n_s & ~cs_d_r;
  logic [DDSL_WORD_W-1:0] shift_r;                        // Serial shift register
  ddsl_sel_t              sel;                            // Decoded channels
  logic [1:0]             addr_bits;                      // Address pair of the word

  // Address pair to channel selects; spelled out per code for clarity
  function automatic ddsl_sel_t chan_decode(input logic [1:0] addr);
    unique case (addr)
      2'h0:    return '{chan_b: 1'b0, chan_a: 1'b0};      // No channel
      2'h1:    return '{chan_b: 1'b0, chan_a: 1'b1};      // Channel A only
      2'h2:    return '{chan_b: 1'b1, chan_a: 1'b0};      // Channel B only
      default: return '{chan_b: 1'b1, chan_a: 1'b1};      // Both channels
    endcase
  endfunction : chan_decode

  // Last 16 bits only: older bits fall off the top
  assign addr_bits = {shift_r[DDSL_ADDR_HI], shift_r[DDSL_ADDR_LO]};
  assign sel       = chan_decode(addr_bits);
  wire [DDSL_CODE_W-1:0] word_code = shift_r[DDSL_CODE_W-1:0]; // Unsigned
  // Preset value picked by level select
  wire [DDSL_CODE_W-1:0] preset_val = lvl_r ? DDSL_HALF : DDSL_ZERO;
  wire force_preset = srst | ~pre_n_s;

  // ==========================================================================
  // Shift register
  // ==========================================================================
  // MSB first: new bit enters at bit 0
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_r <= DDSL_SR_RST;
    end else if (shift_en) begin
      shift_r <= {shift_r[DDSL_WORD_W-2:0], sdi_s};
    end
  end

  // ==========================================================================
  // Input registers
  // ==========================================================================
  // Preset has priority over a concurrent load
  always_ff @(posedge clk) begin
    if (force_preset) begin
      input_reg_a <= preset_val;
      input_reg_b <= preset_val;
    end else if (load_en) begin
      if (sel.chan_a) begin
        input_reg_a <= word_code;
      end
      if (sel.chan_b) begin
        input_reg_b <= word_code;
      end
    end
  end

  // ==========================================================================
  // Converter registers
  // ==========================================================================
  // Preset, then strobe, steers; select is not looked at here
  always_ff @(posedge clk) begin
    if (force_preset) begin
      converter_code_a <= preset_val;
      converter_code_b <= preset_val;
    end else if (!strobe_n_s) begin
      converter_code_a <= input_reg_a;
      converter_code_b <= input_reg_b;
    end
  end                                                     // Else hold

  // ==========================================================================
  // Checks
  // ==========================================================================
  // A load edge: select has just gone high after a frame
  sequence s_sel_rise;
    cs_n_s && !cs_d_r;
  endsequence

  // A serial bit is taken: synced clock rise inside a frame
  sequence s_bit_taken;
    shift_en;
  endsequence

  // Strobe open: converter registers follow the input registers
  sequence s_strobe_open;
    !strobe_n_s;
  endsequence

  // Strobe shut: converter registers are latched
  sequence s_strobe_shut;
    strobe_n_s;
  endsequence

  // Serial path
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (srst)
    s_bit_taken |=> shift_r[0] == $past(sdi_s)
      && shift_r[DDSL_WORD_W-1:1] == $past(shift_r[DDSL_WORD_W-2:0]))
    else $error("shift did not capture data");

  AST_CS_HIGH_HOLD: assert property (@(posedge clk) disable iff (srst)
    cs_n_s |=> $stable(shift_r))
    else $error("shift moved while select high");

  // Input registers
  AST_LOAD_A: assert property (@(posedge clk) disable iff (srst || !pre_n_s)
    s_sel_rise ##0 sel.chan_a |=> input_reg_a == $past(word_code))
    else $error("channel A not loaded");

  AST_LOAD_B: assert property (@(posedge clk) disable iff (srst || !pre_n_s)
    s_sel_rise ##0 sel.chan_b |=> input_reg_b == $past(shift_r[DDSL_CODE_W-1:0]))
    else $error("channel B not loaded from the last bits");

  AST_KEEP_B: assert property (@(posedge clk) disable iff (srst || !pre_n_s)
    s_sel_rise ##0 !sel.chan_b |=> $stable(input_reg_b))
    else $error("unselected B changed");

  AST_KEEP_A: assert property (@(posedge clk) disable iff (srst || !pre_n_s)
    s_sel_rise ##0 !sel.chan_a |=> $stable(input_reg_a))
    else $error("unselected A changed");

  AST_INPUT_LATCHED: assert property (@(posedge clk) disable iff (force_preset)
    !load_en |=> $stable(input_reg_a) && $stable(input_reg_b))
    else $error("input register changed without a load edge");

  // Converter registers
  AST_TRANSP: assert property (@(posedge clk) disable iff (force_preset)
    s_strobe_open |=> converter_code_a == $past(input_reg_a))
    else $error("converter A not transparent");

  AST_TRANSP_B: assert property (@(posedge clk) disable iff (force_preset)
    s_strobe_open |=> converter_code_b == $past(input_reg_b))
    else $error("converter B not transparent");

  AST_HOLD: assert property (@(posedge clk) disable iff (force_preset)
    s_strobe_shut |=> $stable(converter_code_b))
    else $error("converter B changed while strobe high");

  AST_HOLD_A: assert property (@(posedge clk) disable iff (force_preset)
    s_strobe_shut |=> $stable(converter_code_a))
    else $error("converter A changed while strobe high");

  AST_STROBE_ONLY: assert property (@(posedge clk) disable iff (force_preset)
    s_sel_rise ##0 s_strobe_shut |=> $stable(converter_code_a) && $stable(converter_code_b))
    else $error("select edge moved a converter register");

  // Preset: all four registers take the level-selected value
  AST_PRESET: assert property (@(posedge clk) disable iff (srst)
    !pre_n_s |=> input_reg_a == $past(preset_val) && input_reg_b == $past(preset_val)
      && converter_code_a == $past(preset_val) && converter_code_b == $past(preset_val))
    else $error("preset value wrong");
endmodule : ddsl_load

// file: ddsl_pkg.sv
// Package for the dual converter serial load logic.
// Assumes a single system clock domain; pins are synchronised in the top module.
package ddsl_pkg;
  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int         DDSL_WORD_W   = 16;              // Serial word length
  localparam int         DDSL_CODE_W   = 14;              // Converter code width
  localparam int         DDSL_ADDR_HI  = 15;              // Address bit 1 position
  localparam int         DDSL_ADDR_LO  = 14;              // Address bit 0 position
  localparam logic [13:0] DDSL_ZERO    = 14'h0000;        // Zero-scale preset
  localparam logic [13:0] DDSL_HALF    = 14'h2000;        // Half-scale preset
  localparam logic [15:0] DDSL_SR_RST  = 16'h0000;        // Shift register reset

  // Channel select pair
  typedef struct packed {
    logic chan_b;                                         // Channel B selected
    logic chan_a;                                         // Channel A selected
  } ddsl_sel_t;

  // ==========================================================================
  // Asynchronous pins
  // ==========================================================================
  // Carried as one word through both synchroniser stages
  typedef struct packed {
    logic cs_n;                                           // Frame select, idle high
    logic sclk;                                           // Serial clock, idle low
    logic sdata;                                          // Serial data
    logic strobe_n;                                       // Load strobe, idle high
    logic preset_n;                                       // Preset, idle high
  } ddsl_pins_t;

  // Idle level of every pin; synchroniser reset value, so no false edge
  localparam ddsl_pins_t DDSL_PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b0, sdata: 1'b0,
                                          strobe_n: 1'b1, preset_n: 1'b1};
endpackage : ddsl_pkg

// file: ddsl_host.sv
// Host model: drives the three serial pins of the load logic.
// Assumes the 100 MHz bench clock; one link clock period is 8 of its cycles.
`timescale 1ns/1ps
module ddsl_host (
  input  wire logic clk,   // Bench clock
  output logic      cs_n,  // Frame select, idle high
  output logic      sclk,  // Link clock, low outside frames except during idle_clocks
  output logic      sdi    // Data pin, last bit inverted once released
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // One frame of n bits, MSB first; several bytes keep select low
  task automatic send(input logic [31:0] w, input int n);
    @(posedge clk) cs_n <= 1'b0; // Select held low all frame
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi  <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sclk <= 1'b0;
    sdi  <= ~sdi; // Hold over: no stale bit left on the pin
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge clk); // Load latency plus select-high gap
  endtask : send
  // Link clock pulses with select high and data high; must be ignored
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      sdi  <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : idle_clocks
endmodule : ddsl_host

// file: tb_dual_dac_serial_load_logic.sv
// Self-checking bench for the dual converter serial load logic.
// Assumes ddsl_pkg and ddsl_host are compiled first.
`timescale 1ns/1ps
module tb_dual_dac_serial_load_logic;
  import ddsl_pkg::*;
  // ==========================================================================
  // Clock, pins and design
  // ==========================================================================
  logic        clk = 1'b0, srst = 1'b1;               // Clock and reset
  logic        strobe_n = 1'b1, preset_n = 1'b1;      // Load strobe, preset
  logic        half_sel = 1'b1;                       // Preset level select
  wire  logic  cs_n, sclk, sdi;                       // Serial pins
  logic [13:0] ira, irb, cca, ccb;                    // Register outputs
  int          n_errors = 0, cmp_count = 0;           // Tallies
  always #5 clk = ~clk;
  ddsl_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  ddsl_load u_dut (.clk(clk), .srst(srst), .chip_select_n(cs_n), .serial_clk(sclk),
    .serial_data(sdi), .converter_load_strobe_n(strobe_n), .preset_n(preset_n),
    .half_scale_sel(half_sel), .input_reg_a(ira), .input_reg_b(irb),
    .converter_code_a(cca), .converter_code_b(ccb));
  // Compare one value, count it, report a difference at once
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // All four registers at once
  task automatic chk4(input logic [13:0] a, b, c, d);
    check(ira, a);
    check(irb, b);
    check(cca, c);
    check(ccb, d);
  endtask : chk4
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_reset;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk4(DDSL_HALF, DDSL_HALF, DDSL_HALF, DDSL_HALF);
  endtask : s_reset
  // Addresses 01 (channel A alone, full scale), 00 and 11; strobe high keeps converters
  task automatic s_addr;
    u_host.send({2'b01, 14'h3FFF}, 16);
    chk4(14'h3FFF, DDSL_HALF, DDSL_HALF, DDSL_HALF);
    u_host.send({2'b00, 14'h1555}, 16);
    chk4(14'h3FFF, DDSL_HALF, DDSL_HALF, DDSL_HALF);
    u_host.send({8'hA5, 2'b11, 14'h0ABC}, 24); // Three bytes, extra leading byte
    chk4(14'h0ABC, 14'h0ABC, DDSL_HALF, DDSL_HALF);
  endtask : s_addr
  // Transparent while strobe low, held once it rises
  task automatic s_strobe;
    strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk4(14'h0ABC, 14'h0ABC, 14'h0ABC, 14'h0ABC);
    u_host.send({2'b10, 14'h1234}, 16);
    chk4(14'h0ABC, 14'h1234, 14'h0ABC, 14'h1234);
    strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    u_host.send({2'b01, 14'h0001}, 16);
    chk4(14'h0001, 14'h1234, 14'h0ABC, 14'h1234);
  endtask : s_strobe
  // Clock pulses with select high must not move the shift register
  task automatic s_idle_clk;
    u_host.send({2'b11, 14'h2A5A}, 16);
    chk4(14'h2A5A, 14'h2A5A, 14'h0ABC, 14'h1234);
    u_host.idle_clocks(8);
    u_host.send({24'h000000, 8'h3C}, 8); // One byte: upper byte is older bits
    chk4(14'h1A3C, 14'h2A5A, 14'h0ABC, 14'h1234);
  endtask : s_idle_clk
  // Preset to zero scale
  task automatic s_preset;
    half_sel <= 1'b0;
    repeat (4) @(posedge clk);
    preset_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk4(DDSL_ZERO, DDSL_ZERO, DDSL_ZERO, DDSL_ZERO);
    preset_n <= 1'b1;
  endtask : s_preset
  initial begin
    s_reset();
    s_addr();
    s_strobe();
    s_idle_clk();
    s_preset();
    tally_and_finish();
  end
  // Watchdog: the run needs about 11 us
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_dual_dac_serial_load_logic
